// File: hdl/serial_port_instruction_addressing.sv
`timescale 1ns/100ps
`include "spi_port_consts.svh"
module serial_port_instruction_addressing (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       sclk,
	input  wire logic       csn,
	input  wire logic       sdio_in,
	output logic            sdio_out,
	output logic            sdio_oe,
	output logic            serial_output_pin,
	output logic            serial_output_oe,
	output logic            reg_rd_req,
	output logic [12:0]     reg_rd_addr,
	input  wire logic [7:0] reg_rd_data,
	output logic            reg_wr_valid,
	output logic [12:0]     reg_wr_addr,
	output logic [7:0]      reg_wr_data,
	input  wire logic       reg_wr_ready,
	output logic            update_pulse,
	output logic            overrun,
	output logic [7:0]      port_config
);
	logic [2:0]                sclk_s_r;
	logic [2:0]                csn_s_r;
	logic [1:0]                sdi_s_r;
	logic                      sclk_rise;
	logic                      sclk_fall;
	logic                      cs_low;
	logic                      cs_rise;
	logic                      cs_fall;
	logic [7:0]                cfg_r;
	logic                      lsb_first;
	logic                      separate_output_enable;
	spi_port_pkg::port_state_t state_r;
	logic [3:0]                cnt_r;
	logic [15:0]               sr_r;
	logic [15:0]               shift_nxt;
	logic [7:0]                byte_in;
	logic                      rw_r;
	logic [1:0]                length_code_r;
	logic [12:0]               addr_r;
	logic [12:0]               addr_nxt;
	logic [1:0]                bcnt_r;
	logic                      last_byte;
	logic                      instr_done;
	logic                      byte_done;
	logic                      fetch;
	logic [12:0]               fetch_addr;
	logic                      rd_req_r;
	logic [12:0]               rd_addr_r;
	logic                      rd_wait_r;
	logic [7:0]                tx_r;
	logic                      out_bit_r;
	logic                      sdio_oe_r;
	logic                      sep_oe_r;
	logic                      update_r;
	logic                      overrun_r;
	logic                      push;
	wr_buf_if                  bif ();

	// Pins cross into clk through two flops; edges are found between the second and third.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_s_r <= 3'h0;
			csn_s_r  <= 3'h7;
			sdi_s_r  <= 2'h0;
		end else begin
			sclk_s_r <= {sclk_s_r[1:0], sclk};
			csn_s_r  <= {csn_s_r[1:0], csn};
			sdi_s_r  <= {sdi_s_r[0], sdio_in};
		end
	end

	assign sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
	assign sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
	assign cs_low    = ~csn_s_r[1];
	assign cs_rise   = csn_s_r[1] & ~csn_s_r[2];
	assign cs_fall   = ~csn_s_r[1] & csn_s_r[2];

	// Either mirrored copy selects the mode, so a half-written value still behaves.
	assign lsb_first              = cfg_r[`CFG_LSB_LO] | cfg_r[`CFG_LSB_HI];
	assign separate_output_enable = cfg_r[`CFG_SEP_LO] | cfg_r[`CFG_SEP_HI];

	// Both orders fill the same 16-bit register so the instruction fields sit alike.
	assign shift_nxt = lsb_first ? {sdi_s_r[1], sr_r[15:1]} : {sr_r[14:0], sdi_s_r[1]};
	assign byte_in   = lsb_first ? shift_nxt[15:8] : shift_nxt[7:0];

	always_comb begin
		if (lsb_first) begin
			addr_nxt = addr_r + `ADDR_ONE;
		end else if (addr_r == `CFG_ADDR) begin
			addr_nxt = `TOP_ADDR;
		end else begin
			addr_nxt = addr_r - `ADDR_ONE;
		end
	end

	// Streams stop after the top address is accessed, in either direction.
	assign last_byte = (length_code_r == `LEN_STREAM) ? (addr_r == `TOP_ADDR)
	                                                  : (bcnt_r == length_code_r);

	assign instr_done = cs_low & sclk_rise & (state_r == spi_port_pkg::ST_INSTR) & (cnt_r == `INSTR_LAST);
	assign byte_done  = cs_low & sclk_rise & (state_r == spi_port_pkg::ST_DATA) & (cnt_r[2:0] == `BYTE_LAST);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r       <= spi_port_pkg::ST_INSTR;
			cnt_r         <= 4'h0;
			sr_r          <= 16'h0000;
			rw_r          <= 1'b0;
			length_code_r <= 2'h0;
			addr_r        <= 13'h0000;
			bcnt_r        <= 2'h0;
		end else if (cs_rise) begin
			// A stall on a byte boundary keeps everything, except in stream data or after the last byte (ST_DONE); anything else ends the cycle.
			if ((cnt_r[2:0] != 3'h0) || (state_r == spi_port_pkg::ST_DONE) ||
			    ((state_r == spi_port_pkg::ST_DATA) && (length_code_r == `LEN_STREAM))) begin
				state_r <= spi_port_pkg::ST_INSTR;
				cnt_r   <= 4'h0;
				sr_r    <= 16'h0000;
			end
		end else if (cs_low && sclk_rise) begin
			case (state_r)
				spi_port_pkg::ST_INSTR: begin
					sr_r  <= shift_nxt;
					cnt_r <= cnt_r + `BIT_ONE;
					if (cnt_r == `INSTR_LAST) begin
						rw_r          <= shift_nxt[`INSTR_RW_BIT];
						length_code_r <= shift_nxt[`INSTR_LEN_HI:`INSTR_LEN_LO];
						addr_r        <= shift_nxt[`INSTR_ADDR_HI:0];
						bcnt_r        <= 2'h0;
						state_r       <= spi_port_pkg::ST_DATA;
					end
				end
				spi_port_pkg::ST_DATA: begin
					sr_r  <= shift_nxt;
					cnt_r <= cnt_r + `BIT_ONE;
					if (cnt_r[2:0] == `BYTE_LAST) begin
						cnt_r  <= 4'h0;
						bcnt_r <= bcnt_r + 2'h1;
						addr_r <= addr_nxt;
						if (last_byte) begin
							state_r <= spi_port_pkg::ST_DONE;
						end
					end
				end
				spi_port_pkg::ST_DONE: begin
					cnt_r <= 4'h0;
				end
				default: begin
					state_r <= spi_port_pkg::ST_INSTR;
					cnt_r   <= 4'h0;
				end
			endcase
		end
	end

	// Configuration lives here, not behind the update, because it steers this port.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_r <= `CFG_RESET;
		end else if (byte_done && !rw_r && (addr_r == `CFG_ADDR)) begin
			cfg_r <= byte_in;
		end
	end

	// Update strobe lasts one cycle; the byte is still queued to the register side, and reads return reg_rd_data unmasked.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			update_r <= 1'b0;
		end else begin
			update_r <= byte_done & ~rw_r & (addr_r == `TOP_ADDR) & byte_in[`UPDATE_BIT];
		end
	end

	// Written bytes queue for the register side; the host cannot be held off, so loss is flagged.
	assign push             = byte_done & ~rw_r;
	assign bif.in_valid     = push;
	assign bif.in_data      = '{addr: addr_r, data: byte_in};
	assign bif.out_ready    = reg_wr_ready;

	two_entry_buf u_buf (
		.clk    (clk),
		.resetn (resetn),
		.port   (bif)
	);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			overrun_r <= 1'b0;
		end else if (push && !bif.in_ready) begin
			overrun_r <= 1'b1;
		end else if (cs_fall) begin
			overrun_r <= 1'b0;
		end
	end

	// Reads fetch the first byte when the instruction is complete and each later byte right after the previous one is complete.
	assign fetch      = (instr_done & shift_nxt[`INSTR_RW_BIT]) | (byte_done & rw_r & ~last_byte);
	assign fetch_addr = instr_done ? shift_nxt[`INSTR_ADDR_HI:0] : addr_nxt;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_req_r  <= 1'b0;
			rd_addr_r <= 13'h0000;
			rd_wait_r <= 1'b0;
		end else begin
			rd_req_r  <= fetch;
			rd_wait_r <= rd_req_r;
			if (fetch) begin
				rd_addr_r <= fetch_addr;
			end
		end
	end

	// Load has priority; the falling edge comes many cycles later at any legal clock rate.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_r      <= 8'h00;
			out_bit_r <= 1'b0;
		end else if (rd_wait_r) begin
			tx_r <= (rd_addr_r == `CFG_ADDR) ? cfg_r : reg_rd_data;
		end else if (cs_low && sclk_fall && rw_r && (state_r == spi_port_pkg::ST_DATA)) begin
			out_bit_r <= lsb_first ? tx_r[0] : tx_r[7];
			tx_r      <= lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sdio_oe_r <= 1'b0;
			sep_oe_r  <= 1'b0;
		end else begin
			sdio_oe_r <= cs_low & rw_r & (state_r == spi_port_pkg::ST_DATA) & ~separate_output_enable;
			sep_oe_r  <= cs_low & rw_r & (state_r == spi_port_pkg::ST_DATA) & separate_output_enable;
		end
	end

	assign sdio_out          = out_bit_r;
	assign serial_output_pin = out_bit_r;
	assign sdio_oe           = sdio_oe_r;
	assign serial_output_oe  = sep_oe_r;
	assign reg_rd_req        = rd_req_r;
	assign reg_rd_addr       = rd_addr_r;
	assign reg_wr_valid      = bif.out_valid;
	assign reg_wr_addr       = bif.out_data.addr;
	assign reg_wr_data       = bif.out_data.data;
	assign update_pulse      = update_r;
	assign overrun           = overrun_r;
	assign port_config       = cfg_r;
endmodule : serial_port_instruction_addressing

// File: hdl/spi_port_consts.svh
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH

// Register addresses inside the serial port's map.
`define CFG_ADDR         13'h0000
`define TOP_ADDR         13'h0232
`define ADDR_ONE         13'h0001

// Port configuration register fields; every field is mirrored in both nibbles.
`define CFG_RESET        8'h18
`define CFG_SEP_LO       0
`define CFG_LSB_LO       1
`define CFG_LSB_HI       6
`define CFG_SEP_HI       7

// Update bit in the top register.
`define UPDATE_BIT       0

// Instruction word layout.
`define INSTR_RW_BIT     15
`define INSTR_LEN_HI     14
`define INSTR_LEN_LO     13
`define INSTR_ADDR_HI    12

// Length codes.
`define LEN_STREAM       2'h3

// Bit counter limits.
`define INSTR_LAST       4'hf
`define BYTE_LAST        3'h7
`define BIT_ONE          4'h1

`endif

// File: hdl/spi_port_pkg.sv
package spi_port_pkg;

	typedef enum logic [1:0] {
		ST_INSTR,
		ST_DATA,
		ST_DONE
	} port_state_t;

	typedef struct packed {
		logic [12:0] addr;
		logic [7:0]  data;
	} wr_entry_t;

endpackage : spi_port_pkg

// File: hdl/wr_buf_if.sv
`timescale 1ns/100ps
interface wr_buf_if;
	logic                    in_valid;
	logic                    in_ready;
	spi_port_pkg::wr_entry_t in_data;
	logic                    out_valid;
	logic                    out_ready;
	spi_port_pkg::wr_entry_t out_data;

	modport fill  (output in_valid, output in_data, input in_ready);
	modport store (input in_valid, input in_data, output in_ready,
	               output out_valid, output out_data, input out_ready);
	modport drain (input out_valid, input out_data, output out_ready);
endinterface : wr_buf_if

// File: hdl/two_entry_buf.sv
`timescale 1ns/100ps
module two_entry_buf (
	input wire logic clk,
	input wire logic resetn,
	wr_buf_if.store  port
);
	logic                    v0_r;
	logic                    v1_r;
	spi_port_pkg::wr_entry_t d0_r;
	spi_port_pkg::wr_entry_t d1_r;
	logic                    push;
	logic                    pop;

	// The head entry is the output register, so the consumer sees flop outputs.
	assign port.in_ready  = ~v1_r;
	assign port.out_valid = v0_r;
	assign port.out_data  = d0_r;
	assign push           = port.in_valid & ~v1_r;
	assign pop            = v0_r & port.out_ready;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			v0_r <= 1'b0;
			v1_r <= 1'b0;
		end else if (push && !pop) begin
			if (!v0_r) begin
				v0_r <= 1'b1;
			end else begin
				v1_r <= 1'b1;
			end
		end else if (pop && !push) begin
			v0_r <= v1_r;
			v1_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			d0_r <= '0;
			d1_r <= '0;
		end else if (pop) begin
			d0_r <= v1_r ? d1_r : port.in_data;
			if (push && v1_r) begin
				d1_r <= port.in_data;
			end
		end else if (push) begin
			if (!v0_r) begin
				d0_r <= port.in_data;
			end else begin
				d1_r <= port.in_data;
			end
		end
	end
endmodule : two_entry_buf

// File: sim/spi_port_checker.sv
`timescale 1ns/100ps
`include "spi_port_consts.svh"
module spi_port_checker (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        csn,
	input wire logic        sdio_oe,
	input wire logic        serial_output_oe,
	input wire logic        reg_rd_req,
	input wire logic [12:0] reg_rd_addr,
	input wire logic        reg_wr_valid,
	input wire logic [12:0] reg_wr_addr,
	input wire logic [7:0]  reg_wr_data,
	input wire logic        reg_wr_ready,
	input wire logic        update_pulse,
	input wire logic [7:0]  port_config
);
	logic        have_r;
	logic [12:0] prev_r;
	logic [12:0] walk_nxt;
	logic        lsb;
	logic        sep;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Cleared on the pin, so a new frame is never compared with the last one.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			have_r <= 1'b0;
			prev_r <= 13'h0000;
		end else if (csn) begin
			have_r <= 1'b0;
		end else if (reg_rd_req) begin
			have_r <= 1'b1;
			prev_r <= reg_rd_addr;
		end
	end
	assign lsb = port_config[`CFG_LSB_LO] | port_config[`CFG_LSB_HI];
	assign sep = port_config[`CFG_SEP_LO] | port_config[`CFG_SEP_HI];
	assign walk_nxt = lsb ? prev_r + `ADDR_ONE : (prev_r == `CFG_ADDR) ? `TOP_ADDR : prev_r - `ADDR_ONE;
	sequence s_wr_wait;
		reg_wr_valid && !reg_wr_ready;
	endsequence
	sequence s_cs_rise;
		$rose(csn);
	endsequence
	a_cfg_reset_value: assert property ($rose(resetn) |-> port_config == `CFG_RESET)
		else $error("config not at reset value");
	a_rd_walk: assert property (reg_rd_req && have_r |-> reg_rd_addr == walk_nxt)
		else $error("read address out of sequence");
	a_rdreq_pulse: assert property (reg_rd_req |=> !reg_rd_req)
		else $error("read request longer than one cycle");
	a_update_pulse: assert property (update_pulse |=> !update_pulse)
		else $error("update pulse not self clearing");
	a_oe_exclusive: assert property (!(sdio_oe && serial_output_oe))
		else $error("both outputs driven");
	a_shared_select: assert property (sdio_oe |-> !sep)
		else $error("shared pin driven in separate mode");
	a_sep_select: assert property (serial_output_oe |-> sep)
		else $error("separate pin driven in shared mode");
	a_wr_entry_hold: assert property (s_wr_wait |=> reg_wr_valid && $stable(reg_wr_addr) && $stable(reg_wr_data))
		else $error("write entry changed while stalled");
	a_oe_release: assert property (s_cs_rise |-> ##[0:6] !(sdio_oe || serial_output_oe))
		else $error("outputs still driven after deselect");
endmodule : spi_port_checker
bind serial_port_instruction_addressing spi_port_checker u_chk (
	.clk(clk), .resetn(resetn), .csn(csn), .sdio_oe(sdio_oe), .serial_output_oe(serial_output_oe),
	.reg_rd_req(reg_rd_req), .reg_rd_addr(reg_rd_addr), .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr),
	.reg_wr_data(reg_wr_data), .reg_wr_ready(reg_wr_ready), .update_pulse(update_pulse), .port_config(port_config)
);

// File: sim/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
	output logic     sclk,
	output logic     csn,
	output logic     sdio_line,
	input wire logic sdio_out,
	input wire logic sdio_oe,
	input wire logic serial_output_pin,
	input wire logic serial_output_oe
);
	logic       host_oe;
	logic       host_d;
	logic [7:0] wbuf [8];
	logic [7:0] rbuf [8];
	int         stall_at;
	// A released line shows the inverse of the last host bit, never a stale copy.
	assign sdio_line = sdio_oe ? sdio_out : host_oe ? host_d : ~host_d;
	initial begin
		sclk = 1'b0;
		csn = 1'b1;
		host_oe = 1'b0;
		host_d = 1'b0;
		stall_at = -1;
	end
	task shift_byte(input logic [7:0] tx, input logic lsb, input logic sep, input int nb, output logic [7:0] rx);
		logic b;
		for (int i = 0; i < nb; i++) begin
			host_d = lsb ? tx[i] : tx[7-i];
			#24 sclk = 1'b1;
			b = sep ? (serial_output_oe ? serial_output_pin : ~serial_output_pin) : sdio_line;
			rx = lsb ? {b, rx[7:1]} : {rx[6:0], b};
			#24 sclk = 1'b0;
		end
	endtask : shift_byte
	task xfer(input logic lsb, input logic [15:0] ins, input int n, input logic sep);
		logic [7:0] r;
		csn = 1'b0;
		host_oe = 1'b1;
		#24;
		shift_byte(lsb ? ins[7:0] : ins[15:8], lsb, 1'b0, 8, r);
		shift_byte(lsb ? ins[15:8] : ins[7:0], lsb, 1'b0, 8, r);
		host_oe = !ins[15];
		for (int k = 0; k < n; k++) begin
			// A pause is only legal on a byte boundary, so it sits just before a data byte.
			if (k == stall_at) begin
				csn = 1'b1;
				#48 csn = 1'b0;
				#24;
			end
			shift_byte(wbuf[k], lsb, sep, 8, rbuf[k]);
		end
		#24 csn = 1'b1;
		host_oe = 1'b0;
		#48;
	endtask : xfer
	task abort_frame(input int nb);
		logic [7:0] r;
		csn = 1'b0;
		host_oe = 1'b1;
		#24;
		shift_byte(8'hff, 1'b0, 1'b0, nb, r);
		#24 csn = 1'b1;
		host_oe = 1'b0;
		#48;
	endtask : abort_frame
endmodule : spi_host_model

// File: sim/tb_top.sv
`timescale 1ns/100ps
`include "spi_port_consts.svh"
module tb_top;
	logic clk, resetn, sclk, csn, sdio_line, sdio_out, sdio_oe, sop, soe;
	logic reg_rd_req, reg_wr_valid, reg_wr_ready, update_pulse, overrun, upd_seen;
	logic [12:0] reg_rd_addr, reg_wr_addr;
	logic [7:0]  reg_rd_data, reg_wr_data, port_config;
	logic [20:0] wq [$];
	logic [12:0] rq [$];
	int          n_fail, samples_checked;
	always #2 clk = ~clk;
	assign reg_rd_data = reg_rd_addr[7:0] ^ 8'h5a;
	always @(posedge clk) begin
		if (reg_wr_valid === 1'b1 && reg_wr_ready) wq.push_back({reg_wr_addr, reg_wr_data});
		if (reg_rd_req === 1'b1) rq.push_back(reg_rd_addr);
		if (update_pulse === 1'b1) upd_seen = 1'b1;
	end
	serial_port_instruction_addressing DUT (.clk(clk), .resetn(resetn), .sclk(sclk), .csn(csn),
		.sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_output_pin(sop),
		.serial_output_oe(soe), .reg_rd_req(reg_rd_req), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
		.reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
		.reg_wr_ready(reg_wr_ready), .update_pulse(update_pulse), .overrun(overrun), .port_config(port_config));
	spi_host_model host (.sclk(sclk), .csn(csn), .sdio_line(sdio_line), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.serial_output_pin(sop), .serial_output_oe(soe));
	function logic [7:0] f(input logic [12:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction : f
	task chk(input logic [20:0] got, input logic [20:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task test_done;
		$display("checked=%0d failed=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task go(input logic lsb, input logic rd, input logic [1:0] len, input logic [12:0] a, input int n, input logic sep);
		@(posedge clk) #1;
		wq.delete();
		rq.delete();
		host.xfer(lsb, {rd, len, a}, n, sep);
	endtask : go
	task t_lengths;
		for (int c = 0; c < 3; c++) begin
			for (int k = 0; k < 3; k++) host.wbuf[k] = 8'ha0 + 8'(k);
			// Each fixed length (codes 0 to 2) also pauses once on a byte boundary, which must lose nothing.
			host.stall_at = c;
			go(1'b0, 1'b0, 2'(c), 13'h0012, 3, 1'b0);
			chk(21'(wq.size()), 21'(c + 1));
			for (int k = 0; k <= c; k++) chk(wq[k], {13'h0012 - 13'(k), 8'ha0 + 8'(k)});
		end
		host.stall_at = -1;
	endtask : t_lengths
	task t_stream_down;
		host.wbuf = '{8'h77, `CFG_RESET, 8'h01, 8'h55, 8'h55, 8'h00, 8'h00, 8'h00};
		upd_seen = 1'b0;
		go(1'b0, 1'b0, `LEN_STREAM, `ADDR_ONE, 5, 1'b0);
		chk(21'(wq.size()), 21'h3);
		chk(wq[0], {`ADDR_ONE, 8'h77});
		chk(wq[1], {`CFG_ADDR, `CFG_RESET});
		chk(wq[2], {`TOP_ADDR, 8'h01});
		chk(upd_seen, 1'b1);
	endtask : t_stream_down
	task t_lsb_read;
		go(1'b0, 1'b1, 2'h0, `CFG_ADDR, 1, 1'b0);
		chk(host.rbuf[0], `CFG_RESET);
		go(1'b0, 1'b1, 2'h1, 13'h0006, 2, 1'b0);
		chk(host.rbuf[0], f(13'h0006));
		chk(host.rbuf[1], f(13'h0005));
		host.wbuf[0] = 8'h5a;
		go(1'b0, 1'b0, 2'h0, `CFG_ADDR, 1, 1'b0);
		chk(port_config, 8'h5a);
		go(1'b1, 1'b1, `LEN_STREAM, 13'h0230, 5, 1'b0);
		chk(21'(rq.size()), 21'h3);
		for (int k = 0; k < 3; k++) chk(rq[k], 13'h0230 + 13'(k));
		for (int k = 0; k < 3; k++) chk(host.rbuf[k], f(13'h0230 + 13'(k)));
	endtask : t_lsb_read
	task t_sep_read;
		host.wbuf[0] = 8'hdb;
		go(1'b1, 1'b0, 2'h0, `CFG_ADDR, 1, 1'b0);
		go(1'b1, 1'b1, 2'h0, 13'h0007, 1, 1'b1);
		chk(host.rbuf[0], f(13'h0007));
		host.wbuf[0] = `CFG_RESET;
		go(1'b1, 1'b0, 2'h0, `CFG_ADDR, 1, 1'b0);
		chk(port_config, `CFG_RESET);
	endtask : t_sep_read
	task t_overrun;
		@(posedge clk) #1 reg_wr_ready = 1'b0;
		for (int k = 0; k < 3; k++) host.wbuf[k] = 8'h11 * 8'(k + 1);
		go(1'b0, 1'b0, 2'h2, 13'h0040, 3, 1'b0);
		chk(overrun, 1'b1);
		@(posedge clk) #1 reg_wr_ready = 1'b1;
		// Look a little after each edge so the buffer's new state has settled.
		for (int i = 0; i < 20 && reg_wr_valid !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		if (reg_wr_valid !== 1'b0) begin
			n_fail++;
			test_done;
		end else begin
			chk(21'(wq.size()), 21'h2);
			chk(wq[0], {13'h0040, 8'h11});
			chk(wq[1], {13'h003f, 8'h22});
		end
	endtask : t_overrun
	task t_abort;
		@(posedge clk) #1;
		host.abort_frame(5);
		chk(overrun, 1'b0);
		host.wbuf[0] = 8'h3c;
		go(1'b0, 1'b0, 2'h0, 13'h0033, 1, 1'b0);
		chk(21'(wq.size()), 21'h1);
		chk(wq[0], {13'h0033, 8'h3c});
	endtask : t_abort
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		reg_wr_ready = 1'b1;
		upd_seen = 1'b0;
		n_fail = 0;
		samples_checked = 0;
		repeat (3) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(port_config, `CFG_RESET);
		chk({sdio_oe, soe, reg_wr_valid, overrun}, 4'h0);
		t_lengths;
		t_stream_down;
		t_lsb_read;
		t_sep_read;
		t_overrun;
		t_abort;
		test_done;
	end
endmodule : tb_top
